/* File: scope_trigger.v */
// Two-axis scope recorder with distributed trigger and APB register access
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "scope_trigger_defs.vh"

module scope_trigger #(
    parameter DEPTH = 16,
    parameter NSIG  = 8
) (
    // Clock and resets
    input  wire                  mclk,
    input  wire                  rst,
    input  wire                  porRst,
    // APB slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [7:0]            paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    // Sampled sources
    input  wire [2*NSIG*32-1:0]  sigIn,
    input  wire [63:0]           memRdData,
    output reg  [31:0]           memAddr,
    // Status
    output reg                   scopeActive,
    output reg                   imageReady
);

    localparam NAXIS = 2;
    localparam NCH   = 2;
    localparam NSLOT = NAXIS * NCH;
    localparam DW    = $clog2(DEPTH);
    localparam [23:0] DEPTH24 = DEPTH;
    localparam [DW:0] DEPTH_C = DEPTH;

    // ======================================================================
    // Functions
    function [31:0] cfgDefault;
        input integer k;
        begin
            cfgDefault = (k == `CFG_TIME) ? `TIME_RST : 32'h0000_0000;
        end
    endfunction

    function condEval;
        input [31:0] val;
        input [31:0] lim;
        input [2:0]  code;
        begin
            case (code)
                `CMP_EQ: condEval = (val == lim);
                `CMP_NE: condEval = (val != lim);
                `CMP_GT: condEval = ($signed(val) >  $signed(lim));
                `CMP_GE: condEval = ($signed(val) >= $signed(lim));
                `CMP_LT: condEval = ($signed(val) <  $signed(lim));
                `CMP_LE: condEval = ($signed(val) <= $signed(lim));
                default: condEval = 1'b0;
            endcase
        end
    endfunction

    function [31:0] typeCast;
        input [31:0] d;
        input [1:0]  t;
        begin
            case (t)
                `DT_U8:  typeCast = {24'h000000, d[7:0]};
                `DT_U16: typeCast = {16'h0000, d[15:0]};
                `DT_S16: typeCast = {{16{d[15]}}, d[15:0]};
                default: typeCast = d;
            endcase
        end
    endfunction

    // ======================================================================
    // Configuration storage
    reg  [31:0] cfg [0:`NCFG-1];
    reg  [31:0] nv  [0:`NCFG-1];
    reg  [1:0]  bootStep_reg;
    reg  [31:0] mem [0:NSLOT*DEPTH-1];
    reg  [DW+1:0] rdIdx_reg;

    reg  [2:0]  state_reg;
    reg  [DW-1:0] wrPtr_reg;
    reg  [DW:0] fillCnt_reg;
    reg  [DW:0] postCnt_reg;
    reg  [15:0] divCnt_reg;
    reg         trigPend_reg;
    reg  [1:0]  fired_reg;
    reg  [1:0]  firePrev_reg;

    integer k;

    // ======================================================================
    // Bus decode
    wire        setup    = psel & ~penable;
    wire        isCfg    = (paddr >= `OFS_CFG) && (paddr <= `OFS_CFG_END);
    wire [7:0]  cfgOfs   = paddr - `OFS_CFG;
    wire [3:0]  cfgIdx   = cfgOfs[5:2];
    // Unused config slots refuse like unmapped space
    wire        addrOk   = (paddr[1:0] == 2'h0) &&
                           ((isCfg && cfgIdx < `NCFG) || paddr < `OFS_CFG);
    // Refused writes must not alias onto a mapped word
    wire        wrEn     = psel & penable & pready & pwrite & addrOk;
    wire        cmdWr    = wrEn && (paddr == `OFS_CMD);
    wire        cmdStart = cmdWr & pwdata[`CMD_START];
    wire        cmdStop  = cmdWr & pwdata[`CMD_STOP];
    wire        cmdSave  = cmdWr & pwdata[`CMD_SAVE];

    wire        bootStart = (bootStep_reg == 2'h1) &
                            cfg[`CFG_GEN][`GEN_AUTO0];

    // ======================================================================
    // Shared configuration fields
    wire [15:0] divSel  = cfg[`CFG_TIME][`TIME_DIV_LSB +: 16];
    wire [6:0]  pctRaw  = cfg[`CFG_TIME][`TIME_PCT_LSB +: 7];
    wire        repOn   = cfg[`CFG_GEN][`GEN_REP_LSB +: 2] == `REP_ON;
    wire        running = (state_reg == `ST_PRE) ||
                          (state_reg == `ST_ARMED) ||
                          (state_reg == `ST_POST);
    wire        tick    = running && (divCnt_reg == divSel);

    // ======================================================================
    // Trigger evaluation per axis
    wire [NAXIS-1:0] fireLvl;
    wire [NAXIS-1:0] armed;
    wire [NAXIS-1:0] isManual;
    wire [NAXIS-1:0] isImmed;

    genvar a, c;
    generate
        for (a = 0; a < NAXIS; a = a + 1)
        begin : gTrig
            wire [31:0] tc   = cfg[`CFG_TRIG + a];
            wire [1:0]  mode = tc[`TRIG_MODE_LSB +: 2];
            wire [1:0]  op   = tc[`TRIG_OP_LSB +: 2];
            wire [2:0]  sa   = tc[`TRIG_SA_LSB +: 3];
            wire [2:0]  sb   = tc[`TRIG_SB_LSB +: 3];
            wire [31:0] va   = sigIn[(a * NSIG + sa) * 32 +: 32];
            wire [31:0] vb   = sigIn[(a * NSIG + sb) * 32 +: 32];
            wire        ca   = condEval(va, cfg[`CFG_CMP + 2 * a],
                                        tc[`TRIG_CA_LSB +: 3]);
            wire        cb   = condEval(vb, cfg[`CFG_CMP + 2 * a + 1],
                                        tc[`TRIG_CB_LSB +: 3]);
            wire        comb = (op == `OP_AND) ? (ca & cb) :
                               (op == `OP_OR)  ? (ca | cb) :
                               (op == `OP_XOR) ? (ca ^ cb) : (ca & cb);
            assign fireLvl[a]  = (mode == `MODE_SIMPLE) ? ca :
                                 (mode == `MODE_LOGIC)  ? comb : 1'b0;
            assign armed[a]    = tc[`TRIG_ARM];
            assign isManual[a] = tc[`TRIG_ARM] && (mode == `MODE_STOP);
            assign isImmed[a]  = tc[`TRIG_ARM] && (mode == `MODE_START);
        end
    endgenerate

    // OR of armed axes, rising edges only
    wire [NAXIS-1:0] trigEdge = fireLvl & ~firePrev_reg & armed;
    wire        trigAny   = |trigEdge;
    wire        manualAny = |isManual;
    wire        immAny    = |isImmed;

    // ======================================================================
    // Channel sources
    wire [NSLOT*32-1:0] chFlat;

    generate
        for (a = 0; a < NAXIS; a = a + 1)
        begin : gAx
            for (c = 0; c < NCH; c = c + 1)
            begin : gCh
                wire [31:0] cc    = cfg[`CFG_CHAN + c];
                wire [3:0]  sel   = (cc[`CH_INDIV] && a == 1) ?
                                    cc[`CH_SEL1_LSB +: 4] :
                                    cc[`CH_SEL0_LSB +: 4];
                wire [2:0]  sSel  = sel[2:0];
                wire [31:0] sVal  = sigIn[(a * NSIG + sSel) * 32 +: 32];
                wire [31:0] mVal  = typeCast(memRdData[c * 32 +: 32],
                                             cc[`CH_DTYPE_LSB +: 2]);
                wire [1:0]  kind  = cc[`CH_KIND_LSB +: 2];
                assign chFlat[(a * NCH + c) * 32 +: 32] =
                    (kind == `KIND_PARAM)  ? cfg[`CFG_PARAM] :
                    (kind == `KIND_SIGNAL) ? sVal :
                    (kind == `KIND_MEMORY) ? mVal : 32'h0000_0000;
            end
        end
    endgenerate

    // ======================================================================
    // Pre/post split
    // manual mode forces zero pre-trigger share
    wire [6:0]  pctClamp = (pctRaw > `PCT_FULL) ? `PCT_FULL : pctRaw;
    wire [6:0]  effPct   = manualAny ? 7'h00 : pctClamp;
    wire [23:0] preGoal  = DEPTH24 * {17'h00000, effPct};
    wire [23:0] postGoal = DEPTH24 * {17'h00000, `PCT_FULL - effPct};
    wire [DW:0] fillNext = (fillCnt_reg == DEPTH_C) ? fillCnt_reg :
                           fillCnt_reg + 1'b1;
    wire [DW:0] postNext = postCnt_reg + 1'b1;
    wire        preReach  = ({{(23-DW){1'b0}}, fillNext} * 24'h000064)
                            >= preGoal;
    wire        postReach = ({{(23-DW){1'b0}}, postNext} * 24'h000064)
                            >= postGoal;

    wire        stopTrig = cmdStop & manualAny;
    wire        stopEnd  = cmdStop & ~manualAny;
    wire        startEv  = cmdStart | bootStart |
                           ((state_reg == `ST_DONE) & repOn);

    // ======================================================================
    // Image readout
    wire [DW-1:0] oldest  = (fillCnt_reg == DEPTH_C) ? wrPtr_reg :
                            {DW{1'b0}};
    wire [DW-1:0] physIdx = oldest + rdIdx_reg[DW-1:0];
    wire [DW+1:0] memIdx  = {rdIdx_reg[DW+1:DW], physIdx};

    // ======================================================================
    // Configuration, restart load
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (k = 0; k < `NCFG; k = k + 1)
                cfg[k] <= cfgDefault(k);
            bootStep_reg <= 2'h0;
            rdIdx_reg    <= {(DW+2){1'b0}};
            memAddr      <= 32'h0000_0000;
        end
        else
        begin
            if (bootStep_reg != 2'h2)
                bootStep_reg <= bootStep_reg + 2'h1;
            if (bootStep_reg == 2'h0)
            begin
                for (k = 0; k < `NCFG; k = k + 1)
                    cfg[k] <= nv[k];
            end
            else if (wrEn && isCfg && cfgIdx < `NCFG)
                cfg[cfgIdx] <= pwdata;
            if (wrEn && paddr == `OFS_RDIDX)
                rdIdx_reg <= pwdata[DW+1:0];
            memAddr <= {cfg[`CFG_CHAN + 1][`CH_MADDR_LSB +: 16],
                        cfg[`CFG_CHAN][`CH_MADDR_LSB +: 16]};
        end
    end

    // Survives restart; only power-on loads the defaults into it
    always @(posedge mclk or posedge porRst)
    begin
        if (porRst)
        begin
            for (k = 0; k < `NCFG; k = k + 1)
                nv[k] <= cfgDefault(k);
        end
        else if (cmdSave)
        begin
            for (k = 0; k < `NCFG; k = k + 1)
                nv[k] <= cfg[k];
        end
    end

    // ======================================================================
    // Scope memory, no reset needed for data
    always @(posedge mclk)
    begin
        if (tick)
        begin
            for (k = 0; k < NSLOT; k = k + 1)
                mem[k * DEPTH + wrPtr_reg] <= chFlat[k * 32 +: 32];
        end
    end

    // ======================================================================
    // Recorder state machine
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= `ST_IDLE;
            wrPtr_reg    <= {DW{1'b0}};
            fillCnt_reg  <= {(DW+1){1'b0}};
            postCnt_reg  <= {(DW+1){1'b0}};
            divCnt_reg   <= 16'h0000;
            trigPend_reg <= 1'b0;
            fired_reg    <= 2'h0;
            firePrev_reg <= 2'h0;
            scopeActive  <= 1'b0;
            imageReady   <= 1'b0;
        end
        else
        begin
            firePrev_reg <= fireLvl;
            // start on command, after restart with auto start set, or on repeat once done
            if (startEv)
            begin
                state_reg    <= `ST_PRE;
                wrPtr_reg    <= {DW{1'b0}};
                fillCnt_reg  <= {(DW+1){1'b0}};
                postCnt_reg  <= {(DW+1){1'b0}};
                divCnt_reg   <= 16'h0000;
                trigPend_reg <= immAny;
                fired_reg    <= 2'h0;
                scopeActive  <= 1'b1;
                imageReady   <= 1'b0;
            end
            else if (running)
            begin
                divCnt_reg <= tick ? 16'h0000 : divCnt_reg + 16'h0001;
                if (tick)
                begin
                    wrPtr_reg   <= wrPtr_reg + 1'b1;
                    fillCnt_reg <= fillNext;
                end
                case (state_reg)
                    `ST_PRE:
                    begin
                        if (stopEnd)
                            state_reg <= `ST_DONE;
                        else if (stopTrig)
                            state_reg <= `ST_POST;
                        else if (tick && preReach)
                            state_reg <= `ST_ARMED;
                    end
                    `ST_ARMED:
                    begin
                        if (stopEnd)
                            state_reg <= `ST_DONE;
                        else if (stopTrig || trigAny || trigPend_reg)
                        begin
                            state_reg    <= `ST_POST;
                            fired_reg    <= trigEdge;
                            trigPend_reg <= 1'b0;
                        end
                    end
                    `ST_POST:
                    begin
                        if (tick)
                            postCnt_reg <= postNext;
                        if (stopEnd || (tick && postReach))
                            state_reg <= `ST_DONE;
                    end
                    default:
                        state_reg <= `ST_IDLE;
                endcase
                if (stopEnd || (state_reg == `ST_POST && tick && postReach))
                begin
                    scopeActive <= 1'b0;
                    imageReady  <= 1'b1;
                end
            end
            // no repeat: stay done until next start
        end
    end

    // ======================================================================
    // APB slave: zero wait states, answer registered in setup cycle
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~addrOk;
            if (setup && !pwrite && addrOk)
            begin
                if (paddr == `OFS_STAT)
                    prdata <= {26'h0000000, fired_reg, imageReady,
                               state_reg};
                else if (paddr == `OFS_RDIDX)
                    prdata <= {{(30-DW){1'b0}}, rdIdx_reg};
                else if (paddr == `OFS_RDDATA)
                    prdata <= mem[memIdx[DW+1:DW] * DEPTH + memIdx[DW-1:0]];
                else if (isCfg && cfgIdx < `NCFG)
                    prdata <= cfg[cfgIdx];
                else
                    prdata <= 32'h0000_0000;
            end
            else
                prdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

/* File: scope_trigger_defs.vh */
// Register map, field positions, codes and reset values of the scope block
`ifndef SCOPE_TRIGGER_DEFS_VH
`define SCOPE_TRIGGER_DEFS_VH

// ==========================================================================
// Bus offsets
`define OFS_CMD        8'h00
`define OFS_STAT       8'h04
`define OFS_RDIDX      8'h08
`define OFS_RDDATA     8'h0C
`define OFS_CFG        8'h10
`define OFS_CFG_END    8'h3C

// ==========================================================================
// Configuration word indices (byte address = OFS_CFG + 4 * index)
`define NCFG           11
`define CFG_GEN        0
`define CFG_TIME       1
`define CFG_PARAM      2
`define CFG_TRIG       3
`define CFG_CMP        5
`define CFG_CHAN       9

// ==========================================================================
// Command word bits (write pulses)
`define CMD_START      0
`define CMD_STOP       1
`define CMD_SAVE       2

// ==========================================================================
// General word fields
`define GEN_AUTO0      0
`define GEN_AUTO1      1
`define GEN_REP_LSB    4
`define REP_ON         2'h3

// ==========================================================================
// Timing word fields
`define TIME_DIV_LSB   0
`define TIME_PCT_LSB   16
`define PCT_FULL       7'h64
`define TIME_RST       32'h0032_0000

// ==========================================================================
// Trigger word fields
`define TRIG_ARM       0
`define TRIG_MODE_LSB  1
`define TRIG_OP_LSB    3
`define TRIG_CA_LSB    8
`define TRIG_SA_LSB    11
`define TRIG_CB_LSB    16
`define TRIG_SB_LSB    19

// Trigger modes
`define MODE_STOP      2'h0
`define MODE_START     2'h1
`define MODE_SIMPLE    2'h2
`define MODE_LOGIC     2'h3

// Logic operators
`define OP_AND         2'h0
`define OP_OR          2'h1
`define OP_XOR         2'h2

// Comparison conditions (signed)
`define CMP_EQ         3'h0
`define CMP_NE         3'h1
`define CMP_GT         3'h2
`define CMP_GE         3'h3
`define CMP_LT         3'h4
`define CMP_LE         3'h5

// ==========================================================================
// Channel word fields
`define CH_KIND_LSB    0
`define CH_INDIV       2
`define CH_DTYPE_LSB   4
`define CH_SEL0_LSB    8
`define CH_SEL1_LSB    12
`define CH_MADDR_LSB   16

// Channel source kinds
`define KIND_PARAM     2'h0
`define KIND_SIGNAL    2'h1
`define KIND_MEMORY    2'h2

// Memory data types
`define DT_U8          2'h0
`define DT_U16         2'h1
`define DT_S16         2'h2
`define DT_U32         2'h3

// ==========================================================================
// Recorder states
`define ST_IDLE        3'h0
`define ST_PRE         3'h1
`define ST_ARMED       3'h2
`define ST_POST        3'h3
`define ST_DONE        3'h4

`endif

/* File: pc_host.sv */
// Commissioning host model: APB master for register transfers
`timescale 1ns/100ps
`default_nettype none
module pc_host (
    // Clock and answer
    input  wire logic        mclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    // Request
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [7:0]  paddr,
    output var  logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // ========
    // One transfer, held until pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look like a held value
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: scope_trigger_properties.sv */
// Port assertions of the scope recorder
`timescale 1ns/100ps
`default_nettype none
module scope_trigger_properties #(
    parameter DEPTH = 16,
    parameter NSIG  = 8
) (
    // Clock and bus request
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    // Answer and status
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        scopeActive
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    wire logic setup = psel && !penable;
    wire logic inMap = paddr[1:0] == 2'h0 && paddr <= 8'h38;

    // ========
    // Bus and recorder
    a_ready_setup: assert property (setup |=> pready)
        else $error("no answer after setup");
    a_ready_cause: assert property (pready |-> $past(setup))
        else $error("answer without setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("answer held too long");
    a_err_align: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access accepted");
    a_err_range: assert property (setup && paddr > 8'h38 |=> pslverr)
        else $error("unmapped access accepted");
    a_err_none: assert property (setup && inMap |=> !pslverr)
        else $error("mapped access refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_start_active: assert property (
        pready && pwrite && paddr == 8'h00 && pwdata[1:0] == 2'h1
        |-> ##[1:2] scopeActive)
        else $error("start did not begin recording");
    c_start: cover property (pready && pwrite && paddr == 8'h00);
    c_refused: cover property (pslverr);
    c_finish: cover property ($fell(scopeActive));
endmodule
`default_nettype wire

/* File: multi_axis_scope_trigger_tb.sv */
// Self-checking bench of the two-axis scope recorder
`timescale 1ns/100ps
`default_nettype none
`include "scope_trigger_defs.vh"
module multi_axis_scope_trigger_tb;
    logic         mclk, rst, porRst, psel, penable, pwrite, e;
    logic         pready, pslverr, scopeActive, imageReady;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, memAddr, rnd, q, v;
    logic [511:0] sigIn;
    logic [63:0]  memRdData;
    int           fail_count = 0;
    int           n_tests = 0;

    scope_trigger #(.DEPTH(16), .NSIG(8)) scope_trigger_i (
        .mclk(mclk), .rst(rst), .porRst(porRst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sigIn(sigIn), .memRdData(memRdData),
        .memAddr(memAddr), .scopeActive(scopeActive),
        .imageReady(imageReady));
    pc_host host_i (.mclk(mclk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] expMem(input logic [31:0] d,
                                           input logic [1:0] t);
        return t == 2'h3 ? d : t == 2'h2 ? {{16{d[15]}}, d[15:0]} :
               t == 2'h1 ? {16'h0, d[15:0]} : {24'h0, d[7:0]};
    endfunction
    task automatic check(input string n, input logic [31:0] x, g);
        n_tests++;
        if (g !== x)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_i.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a);
        host_i.xfer(1'b0, a, 32'h0, q, e);
    endtask
    task automatic cfg(input int i, input logic [31:0] d);
        wr(8'(`OFS_CFG + 4 * i), d);
    endtask
    task automatic startRec();
        wr(`OFS_CMD, 32'h1);
        repeat (2) @(posedge mclk);
        check("active", 32'h1, 32'(scopeActive));
    endtask
    task automatic waitDone();
        for (int i = 0; i < 400 && imageReady !== 1'b1; i++)
            @(posedge mclk);
        check("done", 32'h1, 32'(imageReady));
    endtask
    task automatic restart(input logic p);
        @(posedge mclk);
        rst <= 1'b1;
        porRst <= p;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        porRst <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        porRst = 1'b1;
        sigIn = '0;
        memRdData = '0;
        rnd = 32'h25;
        restart(1'b1);
        rd(8'h14);
        check("time", `TIME_RST, q);
        rnd = lfsr(rnd);
        wr(`OFS_RDIDX, rnd);
        rd(`OFS_RDIDX);
        check("rdidx", {26'h0, rnd[5:0]}, q);
        rd(8'h3C);
        check("unmapped", 32'h1, 32'(e));
        wr(8'h41, rnd);
        check("misaligned", 32'h1, 32'(e));
        $display("test registers done");
        memRdData <= {rnd, 32'h0};
        cfg(`CFG_TIME, 32'h0032_0003);
        cfg(`CFG_PARAM, ~rnd);
        cfg(`CFG_TRIG, 32'h3);
        cfg(`CFG_CHAN + 1, {rnd[31:16], 10'h0, rnd[1:0], 4'h2});
        startRec();
        check("maddr", {rnd[31:16], 16'h0}, memAddr);
        repeat (50) @(posedge mclk);
        check("slow", 32'h0, 32'(imageReady));
        waitDone();
        repeat (3) @(posedge mclk);
        check("single", 32'h0, 32'(scopeActive));
        wr(`OFS_RDIDX, 32'hF);
        rd(`OFS_RDDATA);
        check("param", ~rnd, q);
        wr(`OFS_RDIDX, 32'h30);
        rd(`OFS_RDDATA);
        check("memory", expMem(rnd, rnd[1:0]), q);
        $display("test immediate done");
        cfg(`CFG_TIME, `TIME_RST);
        cfg(`CFG_TRIG, 32'h1);
        startRec();
        repeat (60) @(posedge mclk);
        check("await stop", 32'h1, 32'(scopeActive));
        wr(`OFS_CMD, 32'h2);
        waitDone();
        cfg(`CFG_TRIG, 32'h205);
        cfg(`CFG_CMP, 32'h7FFF_FFFF);
        for (int m = 2; m < 4; m++)
        begin
            rnd = lfsr(rnd);
            v = {17'h0, rnd[14:0]};
            cfg(`CFG_TRIG + 1, 32'h251A01 | 32'(m << 1));
            cfg(`CFG_CMP + 2, v);
            sigIn[352 +: 32] <= 32'h0;
            startRec();
            repeat (40) @(posedge mclk);
            rd(`OFS_STAT);
            check("armed", 32'h2, {28'h0, q[3:0]});
            sigIn[352 +: 32] <= v + 32'h1;
            waitDone();
            rd(`OFS_STAT);
            // Fired field is a mask: axis 1 alone, done, state 4
            check("fired", 32'h2C, q);
        end
        startRec();
        repeat (40) @(posedge mclk);
        wr(`OFS_CMD, 32'h2);
        repeat (3) @(posedge mclk);
        check("early", 32'h1, 32'(imageReady));
        $display("test triggers done");
        cfg(`CFG_GEN, 32'h30);
        cfg(`CFG_TRIG, 32'h3);
        cfg(`CFG_TRIG + 1, 32'h0);
        startRec();
        waitDone();
        repeat (3) @(posedge mclk);
        check("rearm", 32'h1, 32'(scopeActive));
        cfg(`CFG_GEN, 32'h0);
        wr(`OFS_CMD, 32'h2);
        cfg(`CFG_GEN, 32'h2);
        wr(`OFS_CMD, 32'h4);
        restart(1'b0);
        repeat (2) @(posedge mclk);
        check("auto off", 32'h0, 32'(scopeActive));
        cfg(`CFG_GEN, 32'h1);
        wr(`OFS_CMD, 32'h4);
        cfg(`CFG_GEN, 32'h0);
        restart(1'b0);
        repeat (2) @(posedge mclk);
        check("auto on", 32'h1, 32'(scopeActive));
        $display("test autostart done");
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        $display("BAD watchdog expected end seen hang");
        summarize();
    end
endmodule

bind scope_trigger scope_trigger_properties #(.DEPTH(DEPTH), .NSIG(NSIG))
    scope_trigger_properties_i (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scopeActive(scopeActive));
`default_nettype wire
